// ==== design/adc_conversion_sequencer.sv ====
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"
module adc_conversion_sequencer #(
  parameter logic [7:0][7:0] DIV_TABLE     = {8'd128, 8'd64, 8'd32, 8'd16, 8'd8, 8'd4, 8'd2, 8'd2},
  parameter logic [7:0][2:0] TRIG_MAP      = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0},
  parameter logic [2:0]      FREE_RUN_CODE = 3'h0
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               reset,
  // Avalon-MM slave
  input  wire logic [4:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  output logic [31:0]             readdata,
  output logic                    waitrequest,
  // Trigger sources
  input  wire logic [7:0]         trigIn,
  // Analog side
  input  wire logic               compHigh,
  output logic [3:0]              channelSelect,
  output logic [1:0]              referenceSelect,
  output logic                    sampleHold,
  output logic [9:0]              dacCode,
  output logic                    convActive,
  output logic                    analogEnable
);
  import adc_seq_pkg::*;

  // Software-visible state
  logic                enable_reg;
  logic                autoTrig_reg;
  logic                doneFlag_reg;
  logic                irqEn_reg;
  logic [2:0]          prescalerSelect_reg;
  logic [2:0]          trigSelect_reg;
  logic [7:0]          inputSel_reg;
  logic                powerReduce_reg;
  logic [9:0]          result_reg;
  logic                resultLock_reg;
  // Sequencer state
  conv_state_e         state_reg;
  conv_mode_e          mode_reg;
  logic                startPend_reg;
  logic                firstPend_reg;
  logic [4:0]          cycCnt_reg;
  logic [7:0]          presCnt_reg;
  logic                sarOn_reg;
  logic [3:0]          sarBit_reg;
  logic [2:0]          trigSync_reg;
  logic                enablePrev_reg;

  // Bus decode, prescaler ticks, trigger and phase strobes
  logic                access;
  logic                wrHit;
  logic                rdHit;
  logic                convEn;
  logic [7:0]          divNow;
  logic                riseTick;
  logic                fallTick;
  logic                trigRaw;
  logic                trigEdge;
  logic                isFreeRun;
  logic                lastCycle;
  logic                doneNow;
  logic                shNow;
  logic                startNow;
  logic                trigStart;
  logic                clrFlag;
  logic [31:0]         readValue;

  // Place the 10-bit result into one byte lane
  function automatic byte_t resultByte(input logic [9:0] r, input logic leftAdj, input logic high);
    byte_t b;
    b = `RST_BYTE;
    if (leftAdj) begin
      b = high ? r[9:2] : {r[1:0], 6'h00};
    end else begin
      b = high ? {6'h00, r[9:8]} : r[7:0];
    end
    return b;
  endfunction : resultByte

  // Request is taken on the edge where waitrequest has already dropped
  assign access = (read | write) & ~waitrequest;
  assign wrHit  = access & write;
  assign rdHit  = access & read;
  // Power reduction overrides enable outright
  assign convEn = enable_reg & ~powerReduce_reg;

  // Prescaler ratio lookup; the half point gives the falling edge
  assign divNow   = DIV_TABLE[prescalerSelect_reg];
  // At or past the end point, so a ratio change mid-count never runs the counter round its full range
  assign riseTick = convEn & (presCnt_reg >= divNow - 8'h01);
  assign fallTick = convEn & (presCnt_reg == (divNow >> 1) - 8'h01);

  // Trigger source lookup; the done flag serves as the free-running source
  assign isFreeRun = (trigSelect_reg == FREE_RUN_CODE);
  assign trigRaw   = isFreeRun ? doneFlag_reg : trigIn[TRIG_MAP[trigSelect_reg]];
  // Edge is seen two clocks after the source moves
  assign trigEdge  = trigSync_reg[1] & ~trigSync_reg[2];
  // Only edges while idle count; a level still high never restarts
  assign trigStart = convEn & autoTrig_reg & trigEdge & (state_reg == ST_IDLE) & ~startPend_reg;
  // Start-bit request waits for the next converter rising edge
  assign startNow  = startPend_reg & riseTick & (state_reg == ST_IDLE);

  // Phase decode per conversion kind
  always_comb begin
    lastCycle = 1'b0;
    doneNow   = 1'b0;
    shNow     = 1'b0;
    unique case (mode_reg)
      MODE_FIRST: begin
        lastCycle = cycCnt_reg == `CYC_FIRST_LAST;
        doneNow   = riseTick & lastCycle;
        shNow     = fallTick & (cycCnt_reg == `SH_FIRST_IDX);
      end
      MODE_AUTO: begin
        lastCycle = cycCnt_reg == `CYC_AUTO_LAST;
        doneNow   = fallTick & lastCycle;
        shNow     = riseTick & (cycCnt_reg == `SH_AUTO_IDX);
      end
      MODE_NORMAL: begin
        lastCycle = cycCnt_reg == `CYC_NORMAL_LAST;
        doneNow   = riseTick & lastCycle;
        shNow     = fallTick & (cycCnt_reg == `SH_NORMAL_IDX);
      end
    endcase
    if (state_reg != ST_CONV) begin
      doneNow = 1'b0;
      shNow   = 1'b0;
    end
  end

  // Bus handshake: one wait cycle, read data prepared while waiting
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
    end
  end

  // Register read mux; start bit reads one during any conversion
  always_comb begin
    readValue = 32'h0000_0000;
    unique case (address)
      `OFS_CTRL_A: readValue[7:0] = {enable_reg, startPend_reg | (state_reg == ST_CONV), autoTrig_reg,
                                     doneFlag_reg, irqEn_reg, prescalerSelect_reg};
      `OFS_CTRL_B: readValue[2:0] = trigSelect_reg;
      `OFS_INPUT_SEL: readValue[7:0] = inputSel_reg;
      `OFS_RESULT_LO: readValue[7:0] = resultByte(result_reg, inputSel_reg[`BIT_LEFT_ADJ], 1'b0);
      `OFS_RESULT_HI: readValue[7:0] = resultByte(result_reg, inputSel_reg[`BIT_LEFT_ADJ], 1'b1);
      `OFS_POWER_RED: readValue[0] = powerReduce_reg;
      default: readValue = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      readdata <= 32'h0000_0000;
    end else if ((read | write) & waitrequest) begin
      readdata <= readValue;
    end
  end

  // Software control fields
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      enable_reg          <= 1'b0;
      autoTrig_reg        <= 1'b0;
      irqEn_reg           <= 1'b0;
      prescalerSelect_reg <= 3'h0;
      trigSelect_reg      <= 3'h0;
      inputSel_reg        <= `RST_BYTE;
      powerReduce_reg     <= 1'b0;
    end else if (wrHit) begin
      unique case (address)
        `OFS_CTRL_A: begin
          enable_reg          <= writedata[`BIT_ENABLE];
          autoTrig_reg        <= writedata[`BIT_AUTO_TRIG];
          irqEn_reg           <= writedata[`BIT_IRQ_EN];
          prescalerSelect_reg <= writedata[2:0];
        end
        `OFS_CTRL_B:    trigSelect_reg  <= writedata[2:0];
        `OFS_INPUT_SEL: inputSel_reg    <= writedata[7:0];
        `OFS_POWER_RED: powerReduce_reg <= writedata[0];
        default: ;
      endcase
    end
  end

  // Done flag: hardware set wins over a write-one clear
  assign clrFlag = wrHit & (address == `OFS_CTRL_A) & writedata[`BIT_DONE_FLAG];
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      doneFlag_reg <= 1'b0;
    end else if (doneNow) begin
      doneFlag_reg <= 1'b1;
    end else if (clrFlag) begin
      doneFlag_reg <= 1'b0;
    end
  end

  // Result lock: low read blocks, high read releases
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      resultLock_reg <= 1'b0;
    end else if (rdHit & (address == `OFS_RESULT_LO)) begin
      resultLock_reg <= 1'b1;
    end else if (rdHit & (address == `OFS_RESULT_HI)) begin
      resultLock_reg <= 1'b0;
    end
  end

  // A locked result register drops the finished conversion
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      result_reg <= 10'h000;
    end else if (doneNow & ~resultLock_reg) begin
      result_reg <= dacCode;
    end
  end

  // Prescaler held at zero while disabled, restarted by a trigger
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      presCnt_reg <= 8'h00;
    end else if (~convEn | trigStart | riseTick) begin
      presCnt_reg <= 8'h00;
    end else begin
      presCnt_reg <= presCnt_reg + 8'h01;
    end
  end

  // Trigger synchroniser and edge history; stage 0 feeds only stage 1
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      trigSync_reg <= 3'h0;
    end else begin
      trigSync_reg <= {trigSync_reg[1:0], trigRaw};
    end
  end

  // First conversion after enable takes the long path
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      enablePrev_reg <= 1'b0;
      firstPend_reg  <= 1'b0;
    end else begin
      enablePrev_reg <= convEn;
      if (convEn & ~enablePrev_reg) begin
        firstPend_reg <= 1'b1;
      end else if (startNow | trigStart) begin
        firstPend_reg <= 1'b0;
      end
    end
  end

  // Start request: written one holds until the conversion begins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      startPend_reg <= 1'b0;
    end else if (~convEn | startNow) begin
      startPend_reg <= 1'b0;
    end else if (wrHit & (address == `OFS_CTRL_A) & writedata[`BIT_START] & writedata[`BIT_ENABLE]
                 & (state_reg == ST_IDLE)) begin
      startPend_reg <= 1'b1;
    end
  end

  // Conversion sequencer; start bit falls with completion in single mode
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg  <= ST_IDLE;
      mode_reg   <= MODE_NORMAL;
      cycCnt_reg <= 5'd0;
    end else if (~convEn) begin
      state_reg  <= ST_IDLE;
      cycCnt_reg <= 5'd0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          cycCnt_reg <= 5'd0;
          if (startNow) begin
            state_reg <= ST_CONV;
            mode_reg  <= firstPend_reg ? MODE_FIRST : MODE_NORMAL;
          end else if (trigStart) begin
            state_reg <= ST_CONV;
            mode_reg  <= firstPend_reg ? MODE_FIRST : MODE_AUTO;
          end
        end
        ST_CONV: begin
          if (doneNow) begin
            cycCnt_reg <= 5'd0;
            // Free running chains straight on, start bit stays high
            if (autoTrig_reg & isFreeRun) begin
              mode_reg <= MODE_NORMAL;
            end else begin
              state_reg <= ST_IDLE;
            end
          end else if (riseTick) begin
            cycCnt_reg <= cycCnt_reg + 5'd1;
          end
        end
      endcase
    end
  end

  // Select buffer: follows software while idle or in the last cycle
  // A change during a free-run conversion lands only on the one after.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      channelSelect   <= 4'h0;
      referenceSelect <= 2'h0;
    end else if (convEn & ~startNow & ~trigStart & ((state_reg == ST_IDLE) | lastCycle)) begin
      channelSelect   <= inputSel_reg[3:0];
      referenceSelect <= inputSel_reg[7:6];
    end
  end

  // Successive approximation: one bit per converter rising edge after the sample
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dacCode    <= 10'h000;
      sarOn_reg  <= 1'b0;
      sarBit_reg <= 4'h0;
    end else if (~convEn) begin
      sarOn_reg <= 1'b0;
    end else if (shNow) begin
      dacCode    <= 10'h200;
      sarOn_reg  <= 1'b1;
      sarBit_reg <= `SAR_MSB;
    end else if (sarOn_reg & riseTick) begin
      dacCode[sarBit_reg] <= compHigh;
      if (sarBit_reg != 4'h0) begin
        dacCode[sarBit_reg - 4'h1] <= 1'b1;
        sarBit_reg                 <= sarBit_reg - 4'h1;
      end else begin
        sarOn_reg <= 1'b0;
      end
    end
  end

  // Analog strobes, registered so the pins never glitch
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sampleHold   <= 1'b0;
      convActive   <= 1'b0;
      analogEnable <= 1'b0;
    end else begin
      sampleHold   <= shNow;
      convActive   <= (state_reg == ST_CONV) & ~(doneNow & ~(autoTrig_reg & isFreeRun));
      analogEnable <= convEn;
    end
  end
endmodule : adc_conversion_sequencer

// ==== design/adc_seq_cfg.svh ====
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// Byte offsets on the register bus
`define OFS_CTRL_A     5'h00
`define OFS_CTRL_B     5'h04
`define OFS_INPUT_SEL  5'h08
`define OFS_RESULT_LO  5'h0c
`define OFS_RESULT_HI  5'h10
`define OFS_POWER_RED  5'h14

// Control A fields
`define BIT_ENABLE     7
`define BIT_START      6
`define BIT_AUTO_TRIG  5
`define BIT_DONE_FLAG  4
`define BIT_IRQ_EN     3
// Input select fields
`define BIT_LEFT_ADJ   5
`define RST_BYTE       8'h00

// Converter clock cycle counts (index of the cycle in which a phase ends, on a rising or falling edge)
`define CYC_NORMAL_LAST 5'd12
`define CYC_FIRST_LAST  5'd24
`define CYC_AUTO_LAST   5'd13
`define SH_NORMAL_IDX   5'd1
`define SH_FIRST_IDX    5'd13
`define SH_AUTO_IDX     5'd1
`define SAR_MSB         4'd9
`endif

// ==== design/adc_seq_pkg.sv ====
package adc_seq_pkg;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_FIRST, MODE_AUTO} conv_mode_e;
  typedef enum logic {ST_IDLE, ST_CONV} conv_state_e;
  typedef logic [7:0] byte_t;
endpackage : adc_seq_pkg

// ==== tb/adc_analog_model.sv ====
`timescale 1ns/1ns
module adc_analog_model (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             reset,
  // Levels present on the sixteen inputs
  input  wire logic [15:0][9:0] chanLevel,
  // Converter side
  input  wire logic [3:0]       channelSelect,
  input  wire logic             sampleHold,
  input  wire logic [9:0]       dacCode,
  input  wire logic             analogEnable,
  output logic                  compHigh
);
  logic [9:0] heldLevel;
  logic       noise;

  // Capture the chosen input at the sample instant; later input changes must not leak in
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      heldLevel <= 10'h000;
    else if (sampleHold)
      heldLevel <= chanLevel[channelSelect];
  end

  // An unpowered comparator gives no stable answer, so it wanders
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      noise <= 1'b0;
    else
      noise <= ~noise;
  end

  // The capacitor tracks the input while the sample pulse stands, so the first trial already sees it
  assign compHigh = analogEnable ? ((sampleHold ? chanLevel[channelSelect] : heldLevel) >= dacCode) : noise;
endmodule : adc_analog_model

// ==== tb/adc_seq_checker.sv ====
`timescale 1ns/1ns
module adc_seq_checker (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // Bus handshake
  input wire logic       read,
  input wire logic       write,
  input wire logic       waitrequest,
  // Analog side
  input wire logic [3:0] channelSelect,
  input wire logic       sampleHold,
  input wire logic [9:0] dacCode,
  input wire logic       convActive,
  input wire logic       analogEnable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic [7:0] shGap;
  logic       shSeen;

  // Cycles since the last sample instant; saturates so a long idle never wraps
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      shGap  <= 8'h00;
      shSeen <= 1'b0;
    end else if (sampleHold) begin
      shGap  <= 8'h00;
      shSeen <= 1'b1;
    end else if (shGap != 8'hff) begin
      shGap <= shGap + 8'h01;
    end
  end

  AST_BUS_ANSWER: assert property ($rose(read || write) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");
  AST_SH_PULSE: assert property (sampleHold |=> !sampleHold)
    else $error("sample pulse longer than one cycle");
  AST_SH_IN_CONV: assert property (sampleHold |-> convActive && analogEnable)
    else $error("sample outside a conversion");
  AST_SH_GAP: assert property (sampleHold && shSeen |-> shGap >= 8'd25)
    else $error("conversions shorter than 13 converter cycles");
  AST_SH_AFTER_START: assert property ($rose(convActive) |-> ##[1:30] sampleHold)
    else $error("no sample instant after start");
  AST_SEL_FROZEN: assert property ($rose(convActive) |=> $stable(channelSelect)[*8])
    else $error("channel changed inside a conversion");
  AST_OFF_IDLE: assert property (!analogEnable && !$past(analogEnable) |-> !convActive && !sampleHold)
    else $error("converter active while disabled");
  AST_DAC_HOLD: assert property (!convActive && !$past(convActive) |-> $stable(dacCode))
    else $error("result code moved while idle");
endmodule : adc_seq_checker

bind adc_conversion_sequencer adc_seq_checker checker_inst (.mclk(mclk), .reset(reset), .read(read),
  .write(write), .waitrequest(waitrequest), .channelSelect(channelSelect), .sampleHold(sampleHold),
  .dacCode(dacCode), .convActive(convActive), .analogEnable(analogEnable));

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"
module testbench;
  logic             mclk, reset, read, write, waitrequest, compHigh, sampleHold, convActive, analogEnable;
  logic [4:0]       address;
  logic [31:0]      writedata, readdata;
  logic [7:0]       trigIn, q, sel;
  logic [3:0]       channelSelect;
  logic [1:0]       referenceSelect;
  logic [9:0]       dacCode, old;
  logic [15:0][9:0] lvl;
  logic [31:0]      seed, r;
  int               numErrors, samplesChecked, shCount, n0;

  adc_conversion_sequencer DUT (.mclk(mclk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .trigIn(trigIn),
    .compHigh(compHigh), .channelSelect(channelSelect), .referenceSelect(referenceSelect),
    .sampleHold(sampleHold), .dacCode(dacCode), .convActive(convActive), .analogEnable(analogEnable));
  adc_analog_model partner (.mclk(mclk), .reset(reset), .chanLevel(lvl), .channelSelect(channelSelect),
    .sampleHold(sampleHold), .dacCode(dacCode), .analogEnable(analogEnable), .compHigh(compHigh));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Sample instants seen, used to count conversions
  always @(posedge mclk) begin
    if (sampleHold === 1'b1) shCount++;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Byte a read should show for result v
  function automatic logic [7:0] exp_byte(input logic [9:0] v, input logic left, input logic hi);
    if (left) return hi ? v[9:2] : {v[1:0], 6'h00};
    return hi ? {6'h00, v[9:8]} : v[7:0];
  endfunction : exp_byte

  task automatic stop_test();
    if (numErrors == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One bus access, held until waitrequest is seen low; read byte lands in q
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    address   <= a;
    write     <= wr;
    read      <= ~wr;
    writedata <= {24'h000000, d};
    // No local limit: a slave that never answers is caught by the watchdog
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  // Polls until the start bit drops; bounded so a stuck conversion is reported
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      bus(1'b0, `OFS_CTRL_A, 8'h00);
      n++;
    end while (q[6] !== 1'b0 && n < 100);
    chk(q & 8'h50, 8'h10);
  endtask : wait_done

  task automatic chk_res(input logic [9:0] v, input logic left);
    bus(1'b0, `OFS_RESULT_LO, 8'h00);
    chk(q, exp_byte(v, left, 1'b0));
    bus(1'b0, `OFS_RESULT_HI, 8'h00);
    chk(q, exp_byte(v, left, 1'b1));
  endtask : chk_res

  initial begin
    repeat (20000) @(posedge mclk);
    numErrors++;
    stop_test();
  end

  initial begin
    reset = 1'b1; read = 1'b0; write = 1'b0; address = 5'h00; writedata = 32'h0; trigIn = 8'h00;
    seed = 32'd53; numErrors = 0; samplesChecked = 0; shCount = 0;
    for (int c = 0; c < 16; c++) begin
      r = rnd();
      lvl[c] = r[9:0];
    end
    lvl[0] = 10'h000;
    lvl[1] = 10'h3ff;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    bus(1'b0, `OFS_CTRL_A, 8'h00);
    chk(q, 8'h00);
    bus(1'b1, 5'h1c, 8'hff);
    bus(1'b0, 5'h1c, 8'h00);
    chk(q, 8'h00);
    // Power reduction keeps the analog side off even with enable set
    bus(1'b1, `OFS_POWER_RED, 8'h01);
    bus(1'b1, `OFS_CTRL_A, 8'h80);
    // Let the registered enable settle, else the check passes whatever the override does
    repeat (2) @(posedge mclk);
    chk(analogEnable, 1'b0);
    bus(1'b1, `OFS_POWER_RED, 8'h00);
    bus(1'b1, `OFS_CTRL_A, 8'h80);
    chk(analogEnable, 1'b1);
    bus(1'b1, `OFS_INPUT_SEL, 8'h41);
    sel = 8'h41;
    // Single conversions; the next selection is written while one runs
    for (int i = 0; i < 8; i++) begin
      old = lvl[sel[3:0]];
      bus(1'b1, `OFS_CTRL_A, 8'hc0);
      r = rnd();
      sel = {r[7:5], 1'b0, r[3:0]};
      bus(1'b1, `OFS_INPUT_SEL, sel);
      bus(1'b0, `OFS_CTRL_A, 8'h00);
      chk(q[6], 1'b1);
      wait_done();
      chk({referenceSelect, channelSelect}, {sel[7:6], sel[3:0]});
      chk_res(old, sel[5]);
      bus(1'b1, `OFS_CTRL_A, 8'h90);
    end
    // Low byte read locks out the next result, flag still rises; old still holds the last result
    bus(1'b0, `OFS_RESULT_LO, 8'h00);
    lvl[sel[3:0]] = old ^ 10'h155;
    bus(1'b1, `OFS_CTRL_A, 8'hc0);
    wait_done();
    bus(1'b0, `OFS_RESULT_HI, 8'h00);
    chk(q, exp_byte(old, sel[5], 1'b1));
    chk_res(old, sel[5]);
    // Trigger sources 1 to 7: one edge starts, a second edge and a held level do not
    // Sources 2, 3, 6 and 7 run with the slower prescaler ratio
    for (int k = 1; k < 8; k++) begin
      bus(1'b1, `OFS_CTRL_A, {6'b101100, k[1], 1'b0});
      bus(1'b1, `OFS_CTRL_B, k[7:0]);
      n0 = shCount;
      trigIn <= 8'h01 << k;
      repeat (12) @(posedge mclk);
      trigIn <= 8'h00;
      repeat (2) @(posedge mclk);
      trigIn <= 8'h01 << k;
      repeat (70) @(posedge mclk);
      chk(shCount - n0, 1);
      bus(1'b0, `OFS_CTRL_A, 8'h00);
      chk(q[4], 1'b1);
      trigIn <= 8'h00;
    end
    chk_res(lvl[sel[3:0]], sel[5]);
    // Start bit under auto-trigger gives exactly one conversion
    bus(1'b1, `OFS_CTRL_A, 8'hb0);
    n0 = shCount;
    bus(1'b1, `OFS_CTRL_A, 8'he0);
    wait_done();
    repeat (60) @(posedge mclk);
    chk(shCount - n0, 1);
    // Free running from the flag, never cleared
    // Clear the flag first, so choosing it as source makes no edge and the start bit begins the chain
    bus(1'b1, `OFS_CTRL_A, 8'hb0);
    bus(1'b1, `OFS_CTRL_B, 8'h00);
    n0 = shCount;
    bus(1'b1, `OFS_CTRL_A, 8'he0);
    repeat (120) @(posedge mclk);
    bus(1'b0, `OFS_CTRL_A, 8'h00);
    chk(q[6], 1'b1);
    chk(shCount - n0 > 3, 1'b1);
    bus(1'b1, `OFS_CTRL_A, 8'h00);
    // State and analogEnable drop one edge after enable, convActive one edge later
    repeat (3) @(posedge mclk);
    chk({analogEnable, convActive}, 2'b00);
    stop_test();
  end
endmodule : testbench
